// ### psos_sched.sv
`timescale 1ns/1ps
`include "psos_cfg.svh"
module psos_sched import psos_pkg::*; #(
   parameter int SEC_CYCLES = `PSOS_SEC_CYCLES
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // system control
   input wire logic sys_enable,
   input wire logic flow_demand,
   input wire logic is_leader,
   // settings
   input wire logic [7:0] max_run_time,
   input wire logic [2:0] active_unit_count,
   input wire logic [2:0] simult_unit_limit,
   input wire logic [3:0] spare_role_setting,
   // peer unit status
   input wire logic [3:0] unit_connected,
   input wire logic [3:0] unit_fault,
   input wire logic [3:0] unit_at_max,
   input wire logic [3:0] unit_flowing,
   // schedule outputs
   output logic [3:0] run_cmd,
   output logic [7:0] start_rank,
   output logic [2:0] conn_count,
   output logic [3:0] stag_active
);
   // ---------------------------------------------------------------
   // time base
   // ---------------------------------------------------------------
   logic [27:0] sec_cnt_reg; // cycles within a second
   logic [5:0] min_cnt_reg; // seconds within a minute
   logic sec_tick; // one-cycle pulse per second
   logic min_tick; // one-cycle pulse per minute
   assign sec_tick = sec_cnt_reg == 28'(SEC_CYCLES - 1);
   assign min_tick = sec_tick &&
                     (min_cnt_reg == 6'(`PSOS_SEC_PER_MIN - 1));

   // prescalers for seconds and minutes
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sec_cnt_reg <= 28'h0000000;
         min_cnt_reg <= 6'h00;
      end else begin
         sec_cnt_reg <= sec_tick ? 28'h0000000 : sec_cnt_reg + 28'h0000001;
         if (min_tick) begin
            min_cnt_reg <= 6'h00;
         end else if (sec_tick) begin
            min_cnt_reg <= min_cnt_reg + 6'h01;
         end
      end
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [3:0] run_reg; // run command per unit
   logic [7:0] rank_reg; // 2-bit rank per unit, 0 first
   logic [3:0] stag_reg; // anti-stagnation promotion
   logic [3:0] pend_reg; // exchange waiting for service
   logic [2:0] conn_reg; // connected unit count
   logic en_d_reg; // enable seen last cycle
   psos_idx_t last_reg; // unit started last
   psos_seq_t seq_reg; // start sequencer
   // per-unit timer results
   logic [3:0] half_w, full_w, stagn_w, flow_done_w, run_clr_w;
   // ordering and selection
   logic [3:0] elig_w; // connected and healthy
   logic [5:0] key_w [4]; // {class, rank, address}
   psos_cnt_t pos_w [4]; // place among eligible units
   psos_cnt_t lim_w; // units allowed to run
   psos_cnt_t run_cnt_w; // units now running
   logic [3:0] stop_w, start_w, pend_set_w;
   logic [3:0] sel_w; // one-hot unit serviced now
   psos_idx_t sel_idx_w, cand_idx_w;
   logic cand_ok_w, start_ok_w, act_rise_w;

   assign run_cmd = run_reg;
   assign start_rank = rank_reg;
   assign conn_count = conn_reg;
   assign stag_active = stag_reg;
   assign act_rise_w = sys_enable && !en_d_reg;
   assign elig_w = unit_connected & ~unit_fault;
   assign run_cnt_w = psos_cnt_t'($countones(run_reg));
   // fewer of active count and simultaneous limit
   assign lim_w = (simult_unit_limit < active_unit_count) ?
                  simult_unit_limit : active_unit_count;

   // ---------------------------------------------------------------
   // per-unit timers and order keys
   // ---------------------------------------------------------------
   for (genvar i = 0; i < `PSOS_UNITS; i++) begin : g_unit
      logic [1:0] cls_w; // start class of this unit
      psos_unit_timer u_timer (
         .ref_clk(ref_clk),
         .arst_n(arst_n),
         .sec_tick(sec_tick),
         .min_tick(min_tick),
         .running(run_reg[i]),
         .flowing(unit_flowing[i]),
         .run_clr(run_clr_w[i]),
         .max_run_time(max_run_time),
         .run_half(half_w[i]),
         .run_full(full_w[i]),
         .stagnant(stagn_w[i]),
         .flow_done(flow_done_w[i])
      );
      // stagnant reserve first, plain reserve last
      assign cls_w = (stag_reg[i] && spare_role_setting[i]) ?
                     `PSOS_CLS_STAG_SPARE :
                     stag_reg[i] ? `PSOS_CLS_STAG :
                     spare_role_setting[i] ? `PSOS_CLS_SPARE :
                     `PSOS_CLS_NORMAL;
      // address breaks ties
      assign key_w[i] = {cls_w, rank_reg[2*i +: 2], 2'(i)};
      // exchange causes at stop or after stagnation
      assign pend_set_w[i] = (run_reg[i] && stop_w[i] &&
                              (half_w[i] || full_w[i] ||
                               max_run_time == 8'h00)) ||
                             (flow_done_w[i] && stag_reg[i] &&
                              spare_role_setting[i]);
      // stop on disable, demand, leadership, fault or disconnect, limit or full run
      assign stop_w[i] = !sys_enable || !flow_demand || !is_leader ||
                         !elig_w[i] || full_w[i] || pos_w[i] >= lim_w;
      assign start_w[i] = start_ok_w && cand_idx_w == 2'(i);
      assign run_clr_w[i] = sel_w[i];
   end

   // place of each unit among eligible units
   always_comb begin
      for (int i = 0; i < `PSOS_UNITS; i++) begin
         pos_w[i] = 3'h0;
         for (int j = 0; j < `PSOS_UNITS; j++) begin
            if (elig_w[j] && key_w[j] < key_w[i]) begin
               pos_w[i] = pos_w[i] + 3'h1;
            end
         end
      end
   end

   // lowest-place idle unit inside the limit, and lowest pending unit
   always_comb begin
      cand_ok_w = 1'b0;
      cand_idx_w = 2'h0;
      sel_w = 4'h0;
      sel_idx_w = 2'h0;
      for (int i = `PSOS_UNITS - 1; i >= 0; i--) begin
         // a unit awaiting its exchange waits for its new rank
         if (elig_w[i] && !run_reg[i] && !pend_reg[i] &&
             pos_w[i] < lim_w &&
             (!cand_ok_w || pos_w[i] < pos_w[cand_idx_w])) begin
            cand_ok_w = 1'b1;
            cand_idx_w = 2'(i);
         end
         if (pend_reg[i]) begin
            sel_w = 4'(1 << i);
            sel_idx_w = 2'(i);
         end
      end
   end

   // one start at a time, all running units at maximum
   assign start_ok_w = sys_enable && flow_demand && is_leader &&
                       seq_reg == SEQ_IDLE && cand_ok_w &&
                       run_cnt_w < lim_w &&
                       (run_reg & ~unit_at_max) == 4'h0;

   // ---------------------------------------------------------------
   // run commands and start sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         run_reg <= 4'h0;
         last_reg <= 2'h0;
         seq_reg <= SEQ_IDLE;
      end else begin
         run_reg <= (run_reg & ~stop_w) | start_w;
         case (seq_reg)
            SEQ_IDLE: begin
               if (start_ok_w) begin
                  seq_reg <= SEQ_SETTLE;
                  last_reg <= cand_idx_w;
               end
            end
            SEQ_SETTLE: begin
               // wait for the new unit to reach top speed
               if (unit_at_max[last_reg] || !run_reg[last_reg]) begin
                  seq_reg <= SEQ_IDLE;
               end
            end
            default: seq_reg <= SEQ_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // start order ranks and promotions
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rank_reg <= `PSOS_RANK_INIT;
         pend_reg <= 4'h0;
         stag_reg <= 4'h0;
         en_d_reg <= 1'b0;
         conn_reg <= 3'h0;
      end else begin
         en_d_reg <= sys_enable;
         conn_reg <= psos_cnt_t'($countones(unit_connected));
         // new event wins over service of the same unit
         pend_reg <= (pend_reg & ~sel_w) | pend_set_w;
         // promotion ends with flow, clear wins
         // a stale idle count in the flow pulse cycle cannot re-set it
         stag_reg <= (stag_reg & ~flow_done_w) |
                     (stagn_w & ~run_reg & ~flow_done_w);
         if (act_rise_w) begin
            rank_reg <= `PSOS_RANK_INIT; // address order
            pend_reg <= pend_set_w;
         end else if (sel_w != 4'h0) begin
            // serviced unit to last place, later ones move up
            for (int j = 0; j < `PSOS_UNITS; j++) begin
               if (sel_w[j]) begin
                  rank_reg[2*j +: 2] <= `PSOS_RANK_LAST;
               end else if (rank_reg[2*j +: 2] >
                            rank_reg[2*sel_idx_w +: 2]) begin
                  rank_reg[2*j +: 2] <= rank_reg[2*j +: 2] - 2'h1;
               end
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   sequence s_act_rise;
      sys_enable && !en_d_reg;
   endsequence
   sequence s_full_run;
      (run_reg & full_w) != 4'h0;
   endsequence

   a_order_init: assert property (
      s_act_rise |=> rank_reg == `PSOS_RANK_INIT)
      else $error("start order not reset on activation");
   a_full_stop: assert property (s_full_run |=>
      ((run_reg | ~pend_reg) & $past(run_reg & full_w)) == 4'h0)
      else $error("unit at full run time not stopped and demoted");
   a_zero_swap: assert property (
      (max_run_time == 8'h00 && (run_reg & stop_w) != 4'h0 &&
       !act_rise_w) |=> (pend_reg & $past(run_reg & stop_w)) != 4'h0)
      else $error("zero run time did not request exchange");
   a_one_start: assert property (
      $countones(run_reg & ~$past(run_reg)) <= 1)
      else $error("more than one unit started at once");
   a_start_max: assert property (
      ((run_reg & ~$past(run_reg)) != 4'h0) |->
      ($past(run_reg & ~unit_at_max) == 4'h0 &&
       $past(seq_reg) == SEQ_IDLE))
      else $error("start before running units reached maximum");
   a_start_room: assert property (
      ((run_reg & ~$past(run_reg)) != 4'h0) |->
      $past(run_cnt_w) < $past(lim_w))
      else $error("start beyond the simultaneous limit");
   a_start_place: assert property (
      start_ok_w |-> pos_w[cand_idx_w] < lim_w ##1 run_reg[last_reg])
      else $error("started unit outside the allowed places");
   a_stag_end: assert property (
      ((flow_done_w & stag_reg) != 4'h0) |=>
      (stag_reg & $past(flow_done_w)) == 4'h0)
      else $error("stagnation promotion not ended after flow");
   a_conn_cnt: assert property (
      $past(arst_n) |-> conn_reg == $past($countones(unit_connected)))
      else $error("connected count wrong");
   a_spare_back: assert property (
      (flow_done_w[2] && stag_reg[2] && spare_role_setting[2] &&
       !act_rise_w) |=> pend_reg[2] ##1 rank_reg[5:4] == 2'h3)
      else $error("reserve not returned to minimum priority");
endmodule

// ### psos_cfg.svh
`ifndef PSOS_CFG_SVH
`define PSOS_CFG_SVH
// ----------------------------------------------------------------------
// system size and clock
// ----------------------------------------------------------------------
`define PSOS_UNITS 4
`define PSOS_CLK_HZ 200000000
// cycles per second, derived from the clock rate
`define PSOS_SEC_CYCLES (`PSOS_CLK_HZ * 1)
`define PSOS_SEC_PER_MIN 60
`define PSOS_MIN_PER_HOUR 60
// ----------------------------------------------------------------------
// anti-stagnation timing
// ----------------------------------------------------------------------
`define PSOS_STAG_HOURS 23
`define PSOS_STAG_MIN (`PSOS_STAG_HOURS * `PSOS_MIN_PER_HOUR)
`define PSOS_FLOW_MINUTES 1
`define PSOS_FLOW_SEC (`PSOS_FLOW_MINUTES * `PSOS_SEC_PER_MIN)
// ----------------------------------------------------------------------
// start order classes, lower starts first
// ----------------------------------------------------------------------
`define PSOS_CLS_STAG_SPARE 2'h0
`define PSOS_CLS_STAG 2'h1
`define PSOS_CLS_NORMAL 2'h2
`define PSOS_CLS_SPARE 2'h3
`define PSOS_RANK_LAST 2'h3
// ranks after reset and on activation: unit i holds rank i
`define PSOS_RANK_INIT 8'hE4
`endif

// ### psos_pkg.sv
package psos_pkg;
   // unit index and rank share one width
   typedef logic [1:0] psos_idx_t;
   // counts of units, 0..4
   typedef logic [2:0] psos_cnt_t;
   // start sequencer states
   typedef enum logic {SEQ_IDLE, SEQ_SETTLE} psos_seq_t;
endpackage

// ### psos_unit_timer.sv
`timescale 1ns/1ps
`include "psos_cfg.svh"
// per-unit run-hour, idle and flow timekeeping
module psos_unit_timer import psos_pkg::*; (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // time base
   input wire logic sec_tick,
   input wire logic min_tick,
   // unit state
   input wire logic running,
   input wire logic flowing,
   input wire logic run_clr,
   input wire logic [7:0] max_run_time,
   // results
   output logic run_half,
   output logic run_full,
   output logic stagnant,
   output logic flow_done
);
   // ---------------------------------------------------------------
   // counters
   // ---------------------------------------------------------------
   logic [15:0] run_min_reg; // minutes run since last exchange
   logic [10:0] idle_min_reg; // minutes stationary
   logic [6:0] flow_sec_reg; // seconds of flow in this run
   logic flow_done_reg; // one-cycle pulse
   logic [15:0] et_min; // limit in minutes
   logic flow_last; // last second of minimum flow
   assign et_min = 16'({8'h00, max_run_time} * 16'(`PSOS_MIN_PER_HOUR));
   assign run_half = (et_min != 16'h0000) &&
                     ({run_min_reg, 1'b0} >= {1'b0, et_min});
   assign run_full = (et_min != 16'h0000) && (run_min_reg >= et_min);
   assign stagnant = idle_min_reg >= 11'(`PSOS_STAG_MIN);
   assign flow_last = running && flowing && sec_tick &&
                      (flow_sec_reg == 7'(`PSOS_FLOW_SEC - 1));
   assign flow_done = flow_done_reg;

   // run minutes only while running, cleared at exchange
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         run_min_reg <= 16'h0000;
      end else if (run_clr) begin
         run_min_reg <= 16'h0000;
      end else if (running && min_tick && run_min_reg != 16'hFFFF) begin
         run_min_reg <= run_min_reg + 16'h0001;
      end
   end

   // idle minutes only while stopped, restart after flow
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         idle_min_reg <= 11'h000;
      end else if (flow_done_reg) begin
         idle_min_reg <= 11'h000;
      end else if (!running && min_tick && !stagnant) begin
         idle_min_reg <= idle_min_reg + 11'h001;
      end
   end

   // seconds of flow; pulse once at one minute
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         flow_sec_reg <= 7'h00;
         flow_done_reg <= 1'b0;
      end else begin
         flow_done_reg <= flow_last;
         if (!running) begin
            flow_sec_reg <= 7'h00;
         end else if (flowing && sec_tick &&
                      flow_sec_reg != 7'(`PSOS_FLOW_SEC)) begin
            flow_sec_reg <= flow_sec_reg + 7'h01;
         end
      end
   end
endmodule

// ### psos_peer_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// peer inverters on the far side of the link
// ----------------------------------------------------------------------
// each peer reaches maximum frequency half a cycle after its run command
// and delivers flow while at maximum and not faulted
module psos_peer_model (
   // clock
   input wire logic ref_clk,
   // commands from the scheduler
   input wire logic [3:0] run_cmd,
   // fault state held by the bench
   input wire logic [3:0] unit_fault,
   // status back to the scheduler
   output logic [3:0] unit_at_max,
   output logic [3:0] unit_flowing
);
   // speed ramp, modelled as one falling edge
   initial begin
      unit_at_max = 4'h0;
   end
   always @(negedge ref_clk) begin
      unit_at_max <= run_cmd;
   end
   // a faulted unit delivers nothing
   assign unit_flowing = unit_at_max & ~unit_fault;
endmodule

// ### tb_pump_start_order_scheduler.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// self-checking bench for the start order scheduler
// ----------------------------------------------------------------------
module tb_pump_start_order_scheduler;
   import psos_pkg::*;
   // clock and reset
   logic ref_clk;
   logic arst_n;
   // control and settings
   logic sys_enable;
   logic flow_demand;
   logic is_leader;
   logic [7:0] max_run_time;
   logic [2:0] active_unit_count;
   logic [2:0] simult_unit_limit;
   logic [3:0] spare_role_setting;
   logic [3:0] unit_connected;
   logic [3:0] unit_fault;
   // peer status
   logic [3:0] unit_at_max;
   logic [3:0] unit_flowing;
   // schedule outputs
   logic [3:0] run_cmd;
   logic [7:0] start_rank;
   logic [2:0] conn_count;
   logic [3:0] stag_active;
   // tallies
   int bad_count;
   int n_compared;
   int k;

   // 200 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // one second is one cycle, so a minute is 60 cycles
   psos_sched #(.SEC_CYCLES(1)) DUT (
      .ref_clk(ref_clk), .arst_n(arst_n), .sys_enable(sys_enable),
      .flow_demand(flow_demand), .is_leader(is_leader),
      .max_run_time(max_run_time), .active_unit_count(active_unit_count),
      .simult_unit_limit(simult_unit_limit),
      .spare_role_setting(spare_role_setting),
      .unit_connected(unit_connected), .unit_fault(unit_fault),
      .unit_at_max(unit_at_max), .unit_flowing(unit_flowing),
      .run_cmd(run_cmd), .start_rank(start_rank), .conn_count(conn_count),
      .stag_active(stag_active)
   );

   psos_peer_model peers (
      .ref_clk(ref_clk), .run_cmd(run_cmd), .unit_fault(unit_fault),
      .unit_at_max(unit_at_max), .unit_flowing(unit_flowing)
   );

   // verdict and end of run
   task automatic tally_and_finish;
      if (bad_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // compare one value
   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, seen);
         bad_count++;
      end
   endtask

   // wait a bounded time for a run pattern, stop the run if it never comes
   task automatic wait_run(input logic [3:0] exp, input int lim);
      int n;
      n = 0;
      while (run_cmd !== exp && n < lim) begin
         @(negedge ref_clk);
         n++;
      end
      check("run_cmd", {4'h0, run_cmd}, {4'h0, exp});
      if (run_cmd !== exp) begin
         tally_and_finish();
      end
   endtask

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      bad_count = 0;
      n_compared = 0;
      arst_n = 1'b0;
      sys_enable = 1'b0;
      flow_demand = 1'b0;
      is_leader = 1'b1;
      max_run_time = 8'h01;
      active_unit_count = 3'h2;
      simult_unit_limit = 3'h2;
      spare_role_setting = 4'h0;
      unit_connected = 4'hF;
      unit_fault = 4'h0;
      repeat (5) @(negedge ref_clk);
      // reset values
      check("run_cmd", {4'h0, run_cmd}, 8'h00);
      check("start_rank", start_rank, 8'hE4);
      check("stag_active", {4'h0, stag_active}, 8'h00);
      arst_n = 1'b1;
      @(negedge ref_clk);
      // activation: units start one at a time in order
      sys_enable = 1'b1;
      flow_demand = 1'b1;
      wait_run(4'h1, 4);
      wait_run(4'h3, 8);
      check("conn_count", {5'h00, conn_count}, 8'h04);
      // simultaneous limit below active count
      simult_unit_limit = 3'h1;
      wait_run(4'h1, 4);
      // reserve last, three connected, two active
      simult_unit_limit = 3'h2;
      spare_role_setting = 4'h1;
      unit_connected = 4'h7;
      wait_run(4'h6, 20);
      // reserve replaces a faulted active unit
      unit_fault = 4'h2;
      wait_run(4'h5, 20);
      // losing leadership stops everything
      is_leader = 1'b0;
      wait_run(4'h0, 3);
      is_leader = 1'b1;
      unit_fault = 4'h0;
      spare_role_setting = 4'h0;
      unit_connected = 4'hF;
      // zero limit: exchange at every stop
      max_run_time = 8'h00;
      flow_demand = 1'b1;
      wait_run(4'h3, 10);
      flow_demand = 1'b0;
      wait_run(4'h0, 3);
      repeat (4) @(negedge ref_clk);
      check("start_rank", start_rank, 8'h4E);
      flow_demand = 1'b1;
      wait_run(4'hC, 10);
      // reactivation restores the order
      max_run_time = 8'h01;
      flow_demand = 1'b0;
      wait_run(4'h0, 3);
      sys_enable = 1'b0;
      @(negedge ref_clk);
      sys_enable = 1'b1;
      repeat (2) @(negedge ref_clk);
      check("start_rank", start_rank, 8'hE4);
      // full limit of one hour: stop and move to last place
      active_unit_count = 3'h1;
      simult_unit_limit = 3'h1;
      flow_demand = 1'b1;
      wait_run(4'h1, 5);
      wait_run(4'h2, 4000);
      check("start_rank", start_rank, 8'h93);
      // idle for 23 hours: every unit promoted
      flow_demand = 1'b0;
      k = 0;
      while (stag_active !== 4'hF && k < 90000) begin
         @(negedge ref_clk);
         k++;
      end
      check("stag_active", {4'h0, stag_active}, 8'h0F);
      if (stag_active !== 4'hF) begin
         tally_and_finish();
      end
      // stagnant reserve goes ahead of the other promoted units
      spare_role_setting = 4'h4;
      flow_demand = 1'b1;
      wait_run(4'h4, 5);
      k = 0;
      while (stag_active !== 4'hB && k < 100) begin
         @(negedge ref_clk);
         k++;
      end
      check("stag_active", {4'h0, stag_active}, 8'h0B);
      // reserve back to last place, first promoted unit takes over
      wait_run(4'h2, 10);
      check("start_rank", start_rank, 8'h72);
      k = 0;
      while (stag_active !== 4'h9 && k < 100) begin
         @(negedge ref_clk);
         k++;
      end
      check("stag_active", {4'h0, stag_active}, 8'h09);
      tally_and_finish();
   end
endmodule
